/* common/bduc_cfg.svh */
// constants for the bidirectional up/down counter
// assumes nothing; definitions only
`ifndef BDUC_CFG_SVH
`define BDUC_CFG_SVH
`define BDUC_WIDTH 8
`define BDUC_ZERO 8'h00
`define BDUC_ONE 8'h01
`define BDUC_ALL_ONES 8'hFF
`endif

/* common/bduc_pkg.sv */
// types and count arithmetic for the up/down counter
// assumes bduc_cfg.svh is on the include path
`include "bduc_cfg.svh"
package bduc_pkg;
  typedef logic [`BDUC_WIDTH-1:0] bduc_count_t;

  // one count step, wrapping modulo 256
  function automatic bduc_count_t bduc_step(input bduc_count_t value,
                                            input logic up);
    bduc_count_t result;
    if (up) begin
      result = value + `BDUC_ONE;
    end else begin
      result = value - `BDUC_ONE;
    end
    return result;
  endfunction

  // terminal value in the current direction
  function automatic logic bduc_at_end(input bduc_count_t value,
                                       input logic up);
    logic hit;
    hit = up ? (value == `BDUC_ALL_ONES) : (value == `BDUC_ZERO);
    return hit;
  endfunction
endpackage

/* common/bduc_tc_if.sv */
// carries count state to the terminal count decoder and its answer back
// assumes one instance per counter, no clock of its own
`timescale 1ns/1ps
`default_nettype none
interface bduc_tc_if;
  bduc_pkg::bduc_count_t count;
  logic count_up;
  logic trickle_n;
  logic tc_n;
  modport core (output count, output count_up, output trickle_n,
                input tc_n);
  modport dec (input count, input count_up, input trickle_n,
               output tc_n);
endinterface
`default_nettype wire

/* verilog/bduc_tc_decode.sv */
// terminal count decoder for cascading through trickle enables
// assumes count and controls arrive over bduc_tc_if; purely combinational
`timescale 1ns/1ps
`default_nettype none
module bduc_tc_decode (
  bduc_tc_if.dec tc_bus
);
  always_comb begin
    tc_bus.tc_n = !(!tc_bus.trickle_n &&
                    bduc_pkg::bduc_at_end(tc_bus.count, tc_bus.count_up));
  end
endmodule
`default_nettype wire

/* verilog/bduc_counter.sv */
// eight-stage up/down counter with a shared load/read data bus
// assumes controls other than i_master_clear_n are synchronous to i_clk; the pin wire is resolved
// outside from o_shared_data_bus and o_shared_data_bus_oe
`timescale 1ns/1ps
`default_nettype none
`include "bduc_cfg.svh"
module bduc_counter (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_master_clear_n,
  input wire logic i_sync_clear_n,
  input wire logic i_chip_select_n,
  input wire logic i_parallel_load_enable_n,
  input wire logic i_parallel_count_enable_n,
  input wire logic i_trickle_count_enable_n,
  input wire logic i_count_up,
  input wire logic i_output_enable_n,
  input wire logic [`BDUC_WIDTH-1:0] i_shared_data_bus,
  output logic [`BDUC_WIDTH-1:0] o_shared_data_bus,
  output logic o_shared_data_bus_oe,
  output logic o_terminal_count_n,
  output logic [`BDUC_WIDTH-1:0] o_count
);
  bduc_pkg::bduc_count_t count;
  bduc_pkg::bduc_count_t next_count;
  logic load_now;
  logic count_now;

  bduc_tc_if tc_bus ();

  // load decode relies on partner keeping the pair apart
  assign load_now = !i_chip_select_n && !i_parallel_load_enable_n;
  assign count_now = !i_parallel_count_enable_n &&
                     !i_trickle_count_enable_n;

  // clear first, then load, then count or hold
  always_comb begin
    next_count = count;
    if (!i_sync_clear_n) begin
      next_count = `BDUC_ZERO;
    end else if (load_now) begin
      next_count = i_shared_data_bus;
    end else if (count_now) begin
      next_count = bduc_pkg::bduc_step(count, i_count_up);
    end
  end

  always_ff @(posedge i_clk or negedge i_master_clear_n) begin
    if (!i_master_clear_n) begin
      count <= `BDUC_ZERO;
    end else if (i_sys_rst) begin
      count <= `BDUC_ZERO;
    end else begin
      count <= next_count;
    end
  end

  // bus is input unless chip select and output enable are low and parallel load enable is high
  // bus data follows the cleared register at once
  assign o_shared_data_bus = count;
  assign o_shared_data_bus_oe = !i_chip_select_n &&
                                i_parallel_load_enable_n &&
                                !i_output_enable_n;
  assign o_count = count;

  assign tc_bus.count = count;
  assign tc_bus.count_up = i_count_up;
  assign tc_bus.trickle_n = i_trickle_count_enable_n;

  bduc_tc_decode u_tc (
    .tc_bus(tc_bus.dec)
  );

  // terminal decode result to the pin
  assign o_terminal_count_n = tc_bus.tc_n;

  a_sync_clear_wins: assert property (
    @(posedge i_clk) disable iff (i_sys_rst || !i_master_clear_n)
    !i_sync_clear_n |=> count == `BDUC_ZERO)
    else $error("sync clear did not zero the count");

  a_parallel_load_value: assert property (
    @(posedge i_clk) disable iff (i_sys_rst || !i_master_clear_n)
    (i_sync_clear_n && load_now) |=> count == $past(i_shared_data_bus))
    else $error("parallel load did not take bus data");

  a_hold_parallel_en: assert property (
    @(posedge i_clk) disable iff (i_sys_rst || !i_master_clear_n)
    (i_sync_clear_n && !load_now && i_parallel_count_enable_n)
    |=> $stable(count))
    else $error("count moved with parallel enable high");

  a_hold_trickle_en: assert property (
    @(posedge i_clk) disable iff (i_sys_rst || !i_master_clear_n)
    (i_sync_clear_n && !load_now && i_trickle_count_enable_n)
    |-> o_terminal_count_n ##1 $stable(count))
    else $error("trickle hold failed or terminal low");

  a_count_up_step: assert property (
    @(posedge i_clk) disable iff (i_sys_rst || !i_master_clear_n)
    (i_sync_clear_n && !load_now && count_now && i_count_up)
    |=> count == bduc_pkg::bduc_step($past(count), 1'b1))
    else $error("count up step wrong");

  a_count_down_step: assert property (
    @(posedge i_clk) disable iff (i_sys_rst || !i_master_clear_n)
    (i_sync_clear_n && !load_now && count_now && !i_count_up)
    |=> count == bduc_pkg::bduc_step($past(count), 1'b0))
    else $error("count down step wrong");

  a_bus_float_cs: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_chip_select_n |-> !o_shared_data_bus_oe)
    else $error("bus driven while deselected");

  a_bus_drive_read: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (!i_chip_select_n && i_parallel_load_enable_n)
    |-> (o_shared_data_bus_oe == !i_output_enable_n) &&
        (o_shared_data_bus == count))
    else $error("bus drive does not follow output enable");

  a_terminal_decode: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    !o_terminal_count_n |-> (!i_trickle_count_enable_n &&
      (i_count_up ? count == `BDUC_ALL_ONES : count == `BDUC_ZERO)))
    else $error("terminal count low off the end value");

  a_master_clear_hold: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    !i_master_clear_n |-> (count == `BDUC_ZERO) &&
      (o_shared_data_bus == `BDUC_ZERO))
    else $error("master clear left count or bus nonzero");

  a_sys_rst_clear: assert property (
    @(posedge i_clk) disable iff (!i_master_clear_n)
    i_sys_rst
    |=> count == `BDUC_ZERO)
    else $error("system reset did not zero the count");

  a_cs_ignores_load: assert property (
    @(posedge i_clk) disable iff (i_sys_rst || !i_master_clear_n)
    (i_sync_clear_n && i_chip_select_n && !count_now)
    |=> $stable(count))
    else $error("count moved while deselected and not counting");

  a_tc_trickle_high: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    i_trickle_count_enable_n
    |-> o_terminal_count_n)
    else $error("terminal low with trickle enable high");

  a_tc_low_up: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (!i_trickle_count_enable_n && i_count_up && count == `BDUC_ALL_ONES)
    |-> !o_terminal_count_n)
    else $error("terminal not low at top while counting up");

  a_tc_low_down: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (!i_trickle_count_enable_n && !i_count_up && count == `BDUC_ZERO)
    |-> !o_terminal_count_n)
    else $error("terminal not low at zero while counting down");

  a_wrap_up_zero: assert property (
    @(posedge i_clk) disable iff (i_sys_rst || !i_master_clear_n)
    (i_sync_clear_n && !load_now && count_now && i_count_up &&
     count == `BDUC_ALL_ONES)
    |=> count == `BDUC_ZERO)
    else $error("count up did not wrap to zero");

  a_wrap_down_full: assert property (
    @(posedge i_clk) disable iff (i_sys_rst || !i_master_clear_n)
    (i_sync_clear_n && !load_now && count_now && !i_count_up &&
     count == `BDUC_ZERO)
    |=> count == `BDUC_ALL_ONES)
    else $error("count down did not wrap to all ones");

  a_master_clear_tc: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (!i_master_clear_n && !i_trickle_count_enable_n && !i_count_up)
    |-> !o_terminal_count_n)
    else $error("master clear did not reach terminal counting down");

  a_master_clear_up: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (!i_master_clear_n && i_count_up)
    |-> o_terminal_count_n)
    else $error("terminal low under master clear counting up");

  a_load_floats_bus: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    load_now
    |-> !o_shared_data_bus_oe)
    else $error("bus driven during parallel load");

  a_tc_follows_zero: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (!i_trickle_count_enable_n && count == `BDUC_ZERO)
    |-> (o_terminal_count_n == i_count_up))
    else $error("terminal does not follow direction at zero");

  a_tc_follows_full: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    (!i_trickle_count_enable_n && count == `BDUC_ALL_ONES)
    |-> (o_terminal_count_n == !i_count_up))
    else $error("terminal does not follow direction at top");
endmodule
`default_nettype wire

/* verif/bduc_bus_master.sv */
// bus master model: resolves the shared data wire
// assumes the bench drives only while the counter floats the bus
`timescale 1ns/1ps
`default_nettype none
module bduc_bus_master (
  input wire logic i_clk,
  input wire logic i_drive,
  input wire logic [7:0] i_data,
  input wire logic i_dut_oe,
  input wire logic [7:0] i_dut_data,
  output logic [7:0] o_wire
);
  logic [7:0] last = 8'h00;
  always_comb o_wire = i_dut_oe ? i_dut_data : (i_drive ? i_data : ~last);
  always @(posedge i_clk) last <= o_wire;
endmodule
`default_nettype wire

/* verif/bidir_bus_updown_counter8_test.sv */
// self-checking bench for the up/down counter
// assumes bduc_pkg and bduc_bus_master are compiled first
`timescale 1ns/1ps
`default_nettype none
module bidir_bus_updown_counter8_test;
  logic clk = 0, rst = 1, mc_n = 1, sc_n = 1, cs_n = 1, pe_n = 1;
  logic cep_n = 1, cet_n = 1, up = 1, oe_n = 1, drv = 0, doe, tc_n;
  logic [7:0] din = 8'h00, bus, dout, cnt;
  int error_cnt = 0, checks = 0, cyc = 0;
  bduc_counter DUT (.i_clk(clk), .i_sys_rst(rst), .i_master_clear_n(mc_n),
    .i_sync_clear_n(sc_n), .i_chip_select_n(cs_n),
    .i_parallel_load_enable_n(pe_n), .i_parallel_count_enable_n(cep_n),
    .i_trickle_count_enable_n(cet_n), .i_count_up(up),
    .i_output_enable_n(oe_n), .i_shared_data_bus(bus),
    .o_shared_data_bus(dout), .o_shared_data_bus_oe(doe),
    .o_terminal_count_n(tc_n), .o_count(cnt));
  bduc_bus_master PM (.i_clk(clk), .i_drive(drv), .i_data(din),
    .i_dut_oe(doe), .i_dut_data(dout), .o_wire(bus));
  initial forever #2 clk = ~clk;
  task automatic test_done();
    if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic t_load(input logic [7:0] v);
    @(negedge clk) {cs_n, pe_n, drv, din} = {3'b001, v};
    @(negedge clk) {cs_n, pe_n, drv} = 3'b110;
    chk("load", v, cnt);
  endtask
  task automatic s_load_read();
    t_load(8'h5A);
    @(negedge clk) {cs_n, oe_n} = 2'b00;
    #1 chk("read", 8'h5A, bus);
    chk("oe", 8'h01, {7'h0, doe});
    @(negedge clk) cs_n = 1;
    #1 chk("cs float", 8'h00, {7'h0, doe});
    @(negedge clk) {cs_n, oe_n} = 2'b01;
    #1 chk("oe float", 8'h00, {7'h0, doe});
    @(negedge clk) {cs_n, pe_n, drv, din} = {3'b101, 8'hC3};
    @(negedge clk) chk("cs ignore", 8'h5A, cnt);
    {pe_n, drv} = 2'b10;
  endtask
  task automatic s_count();
    t_load(8'hFE);
    {cep_n, cet_n, up} = 3'b001;
    @(negedge clk) chk("up", 8'hFF, cnt);
    chk("tc up", 8'h00, {7'h0, tc_n});
    @(negedge clk) chk("wrap", 8'h00, cnt);
    chk("tc off", 8'h01, {7'h0, tc_n});
    {cep_n, up} = 2'b10; #1;
    chk("tc down", 8'h00, {7'h0, tc_n});
    @(negedge clk) chk("hold p", 8'h00, cnt);
    {cet_n, cep_n} = 2'b10;
    #1 chk("tc held", 8'h01, {7'h0, tc_n});
    @(negedge clk) chk("hold t", 8'h00, cnt);
    cet_n = 0;
    @(negedge clk) chk("down", 8'hFF, cnt);
    {cep_n, cet_n} = 2'b11;
  endtask
  task automatic s_clear();
    {cs_n, pe_n, drv, din, sc_n} = {3'b001, 8'h33, 1'b0};
    @(negedge clk) chk("sclr", 8'h00, cnt);
    {cs_n, pe_n, drv, sc_n} = 4'b1101;
    t_load(8'h77);
    @(negedge clk) {cs_n, oe_n, cet_n, mc_n} = 4'b0000;
    #1 chk("mclr", 8'h00, cnt);
    chk("mclr bus", 8'h00, bus);
    chk("mclr tc", 8'h00, {7'h0, tc_n});
    @(negedge clk) {cs_n, oe_n, cet_n, mc_n} = 4'b1111;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      test_done();
    end
  end
  initial begin
    repeat (5) @(negedge clk);
    rst = 0;
    chk("reset", 8'h00, cnt);
    s_load_read();
    s_count();
    s_clear();
    test_done();
  end
endmodule
`default_nettype wire
